// File: mbfe_buf2.v
// two-entry byte buffer with valid/ready on both sides
// assumes both sides run on clk; a stall on the drain side backs up to the fill side
`timescale 1ns/100ps
module mbfe_buf2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire clr, // drop all held entries
  input wire in_valid, // fill side word offered
  output wire in_ready, // fill side may push
  input wire [WIDTH-1:0] in_data, // fill side word
  output wire out_valid, // drain side word present
  input wire out_ready, // drain side takes word
  output wire [WIDTH-1:0] out_data // drain side word
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [1:0] wr_q;
  reg [1:0] rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q[0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 2'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (clr) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q[0]] <= in_data;
        wr_q <= {1'b0, ~wr_q[0]};
      end
      if (pop) begin
        rd_q <= {1'b0, ~rd_q[0]};
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: mbfe_front_end.v
// request front end of a register-only bus slave: address filter, frame and crc check,
// register address mapping, remote-command lock, reply gating and timing, ip-reset button
// assumes an upstream byte receiver on clk that marks frame end with rx_eof after the last byte
// Overview of operation
// - transmit only as reply to received request
// - own address: process, then one reply
// - address zero: act, never reply
// - 0 broadcast, 1-247 unit, rest reserved
// - frames at most 256 bytes, four fields
// - address, function, data, two-byte crc16
// - sixteen-bit registers only, no bit access
// - frame address is register number minus one
// - accept unit address and fixed 255
// - locked mode rejects remote control commands
// - set absolute time always accepted
// - reply latency typically 10 ms, max 700
// - button held 1-5 s restores dhcp
// - set-time reply after clock update; invalid gives zero
`timescale 1ns/100ps
`include "mbfe_regs.vh"
module mbfe_front_end #(
  parameter LATENCY_CYC = (`MBFE_CLK_HZ / 1000) * `MBFE_LATENCY_MS,
  parameter PRESS_MIN_CYC = `MBFE_CLK_HZ * `MBFE_PRESS_MIN_S,
  parameter PRESS_MAX_CYC = `MBFE_CLK_HZ * `MBFE_PRESS_MAX_S,
  parameter TW = 27
) (
  input wire clk, // system clock, 20 MHz
  input wire rst_n, // async reset, active low
  input wire rx_valid, // received byte strobe
  output wire rx_ready, // front end can take a byte
  input wire [7:0] rx_data, // received byte
  input wire rx_eof, // end of frame, after its last byte
  input wire [7:0] attached_modular_unit, // address of the attached unit
  input wire intrusive_locked, // 1 = remote control commands locked
  output wire pl_valid, // payload byte present
  input wire pl_ready, // downstream takes payload byte
  output wire [7:0] pl_data, // function code and data, crc removed
  output reg frame_ok, // pulse: frame accepted for processing
  output reg frame_drop, // pulse: frame discarded, flush payload
  output reg [7:0] func_q, // function code of last frame
  output reg [15:0] reg_addr_q, // first data word, register address
  output reg [15:0] reg_num_q, // register number, address plus one
  output reg bcast_q, // last frame was a broadcast
  output reg cmd_reject_q, // last frame is a locked remote command
  input wire proc_done, // downstream finished the request
  input wire clock_updated, // device clock now holds the new time
  input wire datetime_valid, // supplied date-time was a true date
  output wire tx_grant, // reply transmission allowed
  output reg datetime_zero_q, // reply must carry zero date-time
  input wire reply_done, // reply fully sent
  output reg reply_late_q, // reply exceeded worst-case latency
  input wire ip_reset_pin, // reset button, high while pressed
  output reg ip_dhcp_q // pulse: force ip acquisition to dhcp
);
  reg [8:0] cnt_q;
  reg [15:0] crc_q;
  reg [7:0] addr_q;
  reg [7:0] sub_q;
  reg [7:0] hold0_q;
  reg [7:0] hold1_q;
  reg pend_q;
  reg settime_q;
  reg [TW-1:0] lat_q;
  reg btn_s1_q;
  reg btn_s2_q;
  reg [TW-1:0] press_q;
  wire take;
  wire fwd;
  wire match;
  wire is_cmd;
  wire is_settime;
  wire good;
  wire bit_access;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    reg [15:0] t;
    integer k;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `MBFE_CRC_POLY) : (t >> 1);
      end
      crc_byte = t;
    end
  endfunction

  assign take = rx_valid && rx_ready;
  assign match = (addr_q == `MBFE_ADDR_BCAST) || (addr_q == `MBFE_ADDR_OWN) ||
    ((addr_q == attached_modular_unit) && (addr_q >= `MBFE_ADDR_UNI_MIN) &&
    (addr_q <= `MBFE_ADDR_UNI_MAX));
  // two bytes held back so crc never reaches payload
  assign fwd = take && (cnt_q >= `MBFE_IDX_FWD) && (cnt_q <= `MBFE_MAX_FRAME);
  assign bit_access = (func_q == `MBFE_FC_RD_COILS) || (func_q == `MBFE_FC_RD_BITS) ||
    (func_q == `MBFE_FC_WR_COIL) || (func_q == `MBFE_FC_WR_COILS);
  // remote commands are the register write codes and set-time
  assign is_settime = (func_q == `MBFE_FC_IDENT) && (sub_q == `MBFE_SUB_SET_TIME);
  assign is_cmd = (func_q == `MBFE_FC_WR_SINGLE) || (func_q == `MBFE_FC_WR_MULTI) || is_settime;
  assign good = (crc_q == `MBFE_CRC_GOOD) && (cnt_q >= `MBFE_MIN_FRAME) &&
    (cnt_q <= `MBFE_MAX_FRAME) && match && !bit_access;

  mbfe_buf2 #(.WIDTH(8), .DEPTH(2)) mbfe_buf2_inst (
    .clk(clk),
    .rst_n(rst_n),
    .clr(frame_drop),
    .in_valid(fwd),
    .in_ready(rx_ready),
    .in_data(hold0_q),
    .out_valid(pl_valid),
    .out_ready(pl_ready),
    .out_data(pl_data)
  );

  // frame parse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 9'h000;
      crc_q <= `MBFE_CRC_INIT;
      addr_q <= 8'h00;
      sub_q <= 8'h00;
      hold0_q <= 8'h00;
      hold1_q <= 8'h00;
      func_q <= 8'h00;
      reg_addr_q <= 16'h0000;
      reg_num_q <= 16'h0000;
      bcast_q <= 1'b0;
      cmd_reject_q <= 1'b0;
      frame_ok <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      frame_ok <= 1'b0;
      frame_drop <= 1'b0;
      if (rx_eof) begin
        cnt_q <= 9'h000;
        crc_q <= `MBFE_CRC_INIT;
        bcast_q <= (addr_q == `MBFE_ADDR_BCAST);
        cmd_reject_q <= intrusive_locked && is_cmd && !is_settime;
        frame_ok <= good;
        frame_drop <= !good;
      end else if (take) begin
        if (cnt_q != `MBFE_CNT_SAT) begin
          cnt_q <= cnt_q + 9'h001;
        end
        crc_q <= crc_byte(crc_q, rx_data);
        hold1_q <= rx_data;
        hold0_q <= hold1_q;
        if (cnt_q == 9'h000) begin
          addr_q <= rx_data;
        end
        if (cnt_q == `MBFE_IDX_FUNC) begin
          func_q <= rx_data;
        end
        if (cnt_q == `MBFE_IDX_SUB) begin
          sub_q <= rx_data;
          reg_addr_q[15:8] <= rx_data;
        end
        if (cnt_q == `MBFE_IDX_ADR_LO) begin
          reg_addr_q[7:0] <= rx_data;
          reg_num_q <= {reg_addr_q[15:8], rx_data} + `MBFE_REG_OFS;
        end
      end
    end
  end

  // transmit only while a reply is owed
  // set-time reply waits for the clock
  assign tx_grant = pend_q && proc_done && (!settime_q || clock_updated);

  // reply bookkeeping and latency watch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      settime_q <= 1'b0;
      lat_q <= {TW{1'b0}};
      reply_late_q <= 1'b0;
      datetime_zero_q <= 1'b0;
    end else begin
      if (frame_ok) begin
        pend_q <= !bcast_q;
        settime_q <= is_settime;
        lat_q <= {TW{1'b0}};
        reply_late_q <= 1'b0;
      end else if (pend_q && reply_done) begin
        pend_q <= 1'b0;
      end else if (pend_q) begin
        if (lat_q != LATENCY_CYC[TW-1:0]) begin
          lat_q <= lat_q + {{(TW-1){1'b0}}, 1'b1};
        end else begin
          reply_late_q <= 1'b1;
        end
      end
      if (settime_q && clock_updated) begin
        datetime_zero_q <= !datetime_valid;
      end
    end
  end

  // press timing of the ip reset button
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      press_q <= {TW{1'b0}};
      ip_dhcp_q <= 1'b0;
    end else begin
      btn_s1_q <= ip_reset_pin;
      btn_s2_q <= btn_s1_q;
      ip_dhcp_q <= 1'b0;
      if (btn_s2_q) begin
        if (press_q <= PRESS_MAX_CYC[TW-1:0]) begin
          press_q <= press_q + {{(TW-1){1'b0}}, 1'b1};
        end
      end else begin
        press_q <= {TW{1'b0}};
        ip_dhcp_q <= (press_q >= PRESS_MIN_CYC[TW-1:0]) && (press_q <= PRESS_MAX_CYC[TW-1:0]);
      end
    end
  end
endmodule

// File: mbfe_front_end_chk.sv
// port checks for the request front end
// assumes bind into mbfe_front_end, one clock domain
`timescale 1ns/100ps
module mbfe_front_end_chk (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire rx_eof, // frame end
  input wire frame_ok, // accept pulse
  input wire frame_drop, // drop pulse
  input wire [7:0] func_q, // function code
  input wire [15:0] reg_addr_q, // register address
  input wire [15:0] reg_num_q, // register number
  input wire bcast_q, // broadcast flag
  input wire cmd_reject_q, // locked command flag
  input wire intrusive_locked, // lock level
  input wire proc_done, // processing done
  input wire tx_grant, // reply allowed
  input wire ip_reset_pin, // button pin
  input wire ip_dhcp_q // dhcp pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ok_drop_excl: assert property (!(frame_ok && frame_drop))
    else $error("accept and drop together");
  a_eof_verdict: assert property (rx_eof |-> ##[1:2] (frame_ok || frame_drop))
    else $error("no verdict after frame end");
  a_ok_single: assert property (frame_ok |=> !frame_ok)
    else $error("accept pulse too long");
  a_num_map: assert property (frame_ok |=> reg_num_q == reg_addr_q + 16'h0001)
    else $error("register number not address plus one");
  a_reject_lock: assert property (frame_ok && cmd_reject_q |-> intrusive_locked)
    else $error("reject while unlocked");
  a_time_free: assert property (frame_ok && func_q == 8'h2B |-> !cmd_reject_q)
    else $error("set time rejected");
  a_bcast_silent: assert property (bcast_q |-> !tx_grant)
    else $error("reply to broadcast");
  a_grant_done: assert property (tx_grant |-> proc_done)
    else $error("reply before processing done");
  a_dhcp_single: assert property (ip_dhcp_q |=> !ip_dhcp_q)
    else $error("dhcp pulse too long");
  a_dhcp_release: assert property (ip_dhcp_q |-> !ip_reset_pin)
    else $error("dhcp while button held");
endmodule
bind mbfe_front_end mbfe_front_end_chk mbfe_front_end_chk_inst (.clk(clk), .rst_n(rst_n), .rx_eof(rx_eof),
  .frame_ok(frame_ok), .frame_drop(frame_drop), .func_q(func_q), .reg_addr_q(reg_addr_q), .reg_num_q(reg_num_q),
  .bcast_q(bcast_q), .cmd_reject_q(cmd_reject_q), .intrusive_locked(intrusive_locked), .proc_done(proc_done),
  .tx_grant(tx_grant), .ip_reset_pin(ip_reset_pin), .ip_dhcp_q(ip_dhcp_q));

// File: mbfe_front_end_test.sv
// testbench for the request front end with a master model
// assumes shortened timing parameters; inputs change at the falling edge
`timescale 1ns/100ps
module mbfe_front_end_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg pl_ready = 1'b1;
  reg locked = 1'b0;
  reg done = 1'b0;
  reg upd = 1'b0;
  reg rdone = 1'b0;
  reg pin = 1'b0;
  reg dtv = 1'b1;
  wire rx_valid, rx_ready, rx_eof, pl_valid, ok, drop, bc, rej, grant, dz, late, dhcp;
  wire [7:0] rx_data, pl_data, func;
  wire [15:0] adr, num;
  integer n_fail = 0;
  integer checks_done = 0;
  reg [39:0] pl_log = 40'h0000000000;
  integer pl_cnt = 0;
  always #25 clk = ~clk;
  // payload words logged once settled after the stimulus edge
  always @(negedge clk) begin
    #1;
    if (pl_valid && pl_ready) begin
      pl_log = {pl_log[31:0], pl_data};
      pl_cnt = pl_cnt + 1;
    end
  end
  mbfe_front_end #(.LATENCY_CYC(50), .PRESS_MIN_CYC(20), .PRESS_MAX_CYC(100)) mbfe_front_end_inst (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_eof(rx_eof),
    .attached_modular_unit(8'h2F), .intrusive_locked(locked), .pl_valid(pl_valid), .pl_ready(pl_ready),
    .pl_data(pl_data), .frame_ok(ok), .frame_drop(drop), .func_q(func), .reg_addr_q(adr), .reg_num_q(num),
    .bcast_q(bc), .cmd_reject_q(rej), .proc_done(done), .clock_updated(upd), .datetime_valid(dtv),
    .tx_grant(grant), .datetime_zero_q(dz), .reply_done(rdone), .reply_late_q(late),
    .ip_reset_pin(pin), .ip_dhcp_q(dhcp));
  mbfe_master_model mbfe_master_model_inst (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eof(rx_eof));
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task payload(input [39:0] e);
    begin
      chk(pl_cnt, 16'h0005);
      chk(pl_log[39:24], e[39:24]);
      chk(pl_log[23:8], e[23:8]);
      chk(pl_log[7:0], e[7:0]);
    end
  endtask
  task frame(input [47:0] b, input [15:0] flip, input e);
    integer k;
    reg o, d;
    begin
      o = 1'b0;
      d = 1'b0;
      pl_cnt = 0;
      mbfe_master_model_inst.send(b, flip);
      // the verdict pulse stands in the cycle in which send returns
      for (k = 0; k < 4; k = k + 1) begin
        o = o | ok;
        d = d | drop;
        @(negedge clk);
      end
      chk({o, d}, {e, !e});
      chk(mbfe_master_model_inst.stalls, 16'h0000);
      if (mbfe_master_model_inst.stalls != 0)
        complete_run;
    end
  endtask
  task reply(input e);
    begin
      done = 1'b1;
      @(negedge clk);
      chk(grant, e);
      rdone = 1'b1;
      @(negedge clk);
      rdone = 1'b0;
      done = 1'b0;
      upd = 1'b0;
      @(negedge clk);
    end
  endtask
  task t_uni;
    begin
      frame(48'h2F03522C000A, 16'h0000, 1'b1);
      payload(40'h03522C000A);
      chk(adr, 16'h522C);
      chk(num, 16'h522D);
      chk({func, 7'h00, bc}, 16'h0300);
      chk(grant, 1'b0);
      reply(1'b1);
      chk(grant, 1'b0);
      $display("test unicast done");
    end
  endtask
  task t_filter;
    begin
      frame(48'h0010000A0001, 16'h0000, 1'b1);
      chk(bc, 1'b1);
      reply(1'b0);
      frame(48'hF803522C000A, 16'h0000, 1'b0);
      frame(48'hFE03522C000A, 16'h0000, 1'b0);
      frame(48'h3003522C000A, 16'h0000, 1'b0);
      frame(48'h2F03522C000A, 16'h0100, 1'b0);
      frame(48'h2F01522C000A, 16'h0000, 1'b0);
      frame(48'hFF03522C000A, 16'h0000, 1'b1);
      $display("test address filter done");
    end
  endtask
  task t_lock;
    begin
      locked = 1'b1;
      pl_ready = 1'b0;
      fork
        frame(48'h2F06522C000A, 16'h0000, 1'b1);
        begin
          repeat (14) @(negedge clk);
          chk(rx_ready, 1'b0);
          pl_ready = 1'b1;
        end
      join
      chk(rej, 1'b1);
      payload(40'h06522C000A);
      frame(48'h2F2B10000E0A, 16'h0000, 1'b1);
      chk(rej, 1'b0);
      done = 1'b1;
      @(negedge clk);
      chk(grant, 1'b0);
      upd = 1'b1;
      reply(1'b1);
      chk(dz, 1'b0);
      dtv = 1'b0;
      frame(48'h2F2B10000E0A, 16'h0000, 1'b1);
      upd = 1'b1;
      reply(1'b1);
      chk(dz, 1'b1);
      dtv = 1'b1;
      locked = 1'b0;
      frame(48'h2F06522C000A, 16'h0000, 1'b1);
      chk(rej, 1'b0);
      chk(late, 1'b0);
      repeat (60) @(negedge clk);
      chk(late, 1'b1);
      reply(1'b1);
      $display("test lock done");
    end
  endtask
  task press(input integer len, input e);
    reg v;
    begin
      v = 1'b0;
      pin = 1'b1;
      repeat (len) @(negedge clk);
      pin = 1'b0;
      repeat (10) begin
        @(negedge clk);
        v = v | dhcp;
      end
      chk(v, e);
    end
  endtask
  task t_button;
    begin
      press(50, 1'b1);
      press(5, 1'b0);
      press(130, 1'b0);
      $display("test button done");
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_uni;
    t_filter;
    t_lock;
    t_button;
    complete_run;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    complete_run;
  end
endmodule

// File: mbfe_master_model.sv
// bus master model: sends one request frame byte by byte
// assumes a byte is taken on a rising edge with rx_valid and rx_ready
`timescale 1ns/100ps
module mbfe_master_model (
  input wire clk, // system clock
  input wire rx_ready, // front end has room
  output reg rx_valid, // byte strobe
  output reg [7:0] rx_data, // byte
  output reg rx_eof // end of frame
);
  // bytes whose stall outlasted the bound
  integer stalls;
  initial begin
    stalls = 0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eof = 1'b0;
  end
  function [15:0] crc16(input [15:0] c, input [7:0] b);
    integer k;
    begin
      crc16 = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1)
        crc16 = crc16[0] ? (crc16 >> 1) ^ 16'hA001 : crc16 >> 1;
    end
  endfunction
  task send(input [47:0] b, input [15:0] flip);
    reg [15:0] c;
    reg [63:0] f;
    integer i, n;
    begin
      c = 16'hFFFF;
      for (i = 0; i < 6; i = i + 1)
        c = crc16(c, b[47-8*i -: 8]);
      c = c ^ flip;
      f = {b, c[7:0], c[15:8]};
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = f[63-8*i -: 8];
        for (n = 0; n < 100 && !rx_ready; n = n + 1)
          @(negedge clk);
        if (!rx_ready)
          stalls = stalls + 1;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_eof = 1'b1;
      @(negedge clk);
      rx_eof = 1'b0;
    end
  endtask
endmodule

// File: mbfe_regs.vh
// constants for the request front end: address decode, frame limits, function codes, timing
// assumes a 20 MHz system clock; included by its bare name
`ifndef MBFE_REGS_VH
`define MBFE_REGS_VH
`define MBFE_ADDR_BCAST 8'h00
`define MBFE_ADDR_UNI_MIN 8'h01
`define MBFE_ADDR_UNI_MAX 8'hF7
`define MBFE_ADDR_OWN 8'hFF
`define MBFE_MAX_FRAME 9'h100
`define MBFE_CNT_SAT 9'h1FF
`define MBFE_MIN_FRAME 9'h004
`define MBFE_IDX_FUNC 9'h001
`define MBFE_IDX_SUB 9'h002
`define MBFE_IDX_ADR_HI 9'h002
`define MBFE_IDX_ADR_LO 9'h003
`define MBFE_IDX_FWD 9'h003
`define MBFE_CRC_INIT 16'hFFFF
`define MBFE_CRC_POLY 16'hA001
`define MBFE_CRC_GOOD 16'h0000
`define MBFE_FC_WR_SINGLE 8'h06
`define MBFE_FC_WR_MULTI 8'h10
`define MBFE_FC_IDENT 8'h2B
`define MBFE_FC_RD_COILS 8'h01
`define MBFE_FC_RD_BITS 8'h02
`define MBFE_FC_WR_COIL 8'h05
`define MBFE_FC_WR_COILS 8'h0F
`define MBFE_SUB_SET_TIME 8'h10
`define MBFE_REG_OFS 16'h0001
`define MBFE_CLK_HZ 20000000
`define MBFE_LATENCY_MS 700
`define MBFE_PRESS_MIN_S 1
`define MBFE_PRESS_MAX_S 5
`endif
